// >>> can_bus_model.sv
// Behavioural model of the CAN bus as seen by the receive side
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
    // Clock and frame start
    input  wire logic CLK,
    input  wire logic go,
    // Bus view
    output var  logic CAN_RX,
    output var  logic RX_BUSY,
    output var  logic BIT_TICK
);
    logic [4:0] n = 5'h00;
    // One bit per clock keeps frames and sync counts short
    assign BIT_TICK = 1'b1;
    assign RX_BUSY  = (n != 5'h00);
    // Dominant header, then alternating bits: never 11 recessive inside a frame
    assign CAN_RX   = (n == 5'h00) | (n[0] & ~n[4]);
    // Frame length counter
    always @(posedge CLK) n <= go ? 5'h1F : n - {4'h0, RX_BUSY};
endmodule : can_bus_model
`default_nettype wire

// >>> can_mode_control_status.sv
// Mode control, master status and receive FIFO pointer logic of the CAN controller
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module can_mode_control_status
    import can_mode_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    // CAN receive pin
    input  wire logic        CAN_RX,
    // Protocol engine status
    input  wire logic        BIT_TICK,
    input  wire logic        RX_BUSY,
    input  wire logic        TX_BUSY,
    input  wire logic        BUS_OFF,
    input  wire logic        ERR_EVENT,
    input  wire logic        TX_FAIL,
    // Transmit mailboxes
    input  wire logic [1:0]  MB_PENDING,
    input  wire logic [10:0] MB0_ID,
    input  wire logic [10:0] MB1_ID,
    input  wire logic        MB1_OLDER,
    // Receive FIFO events
    input  wire logic        MSG_STORE,
    input  wire logic        FIFO_RELEASE,
    // Engine control
    output var  logic [1:0]  MODE,
    output var  logic        BUSOFF_EXIT,
    output var  logic        TX_RETRY,
    output var  logic        TX_ABORT,
    output var  logic        TX_SELECT,
    output var  logic        STORE_WE,
    output var  logic [1:0]  STORE_SLOT,
    output var  logic        RX_DISCARD,
    output var  logic [1:0]  READ_SLOT,
    output var  logic [1:0]  FIFO_PENDING,
    output var  logic        STATUS_IRQ
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ctrl_t       ctrl;
    mode_t       mode;
    mode_t       next_mode;
    logic [7:0]  irq_en;
    logic        rx_meta;
    logic        rx_sync;
    logic        rx_prev;
    logic        sof;
    logic        busy;
    logic        rx_active;
    logic        tx_active;
    logic        wakeup_flag;
    logic        error_flag;
    logic [3:0]  sync_cnt;
    logic        sync_done;
    logic [3:0]  rec_bits;
    logic [6:0]  rec_groups;
    logic        sw_recover;
    logic        rec_run;
    logic [1:0]  wptr;
    logic [1:0]  last_slot;
    logic        stale;
    logic        rel_ok;
    logic        full_now;
    logic        apb_wr;
    logic        ctrl_wr;
    logic        stat_wr;
    logic        ie_wr;
    logic        mapped;
    logic [7:0]  status_val;
    logic [7:0]  read_val;

    // ------------------------------------------------------------------
    // Receive pin synchroniser and start-of-frame edge
    // ------------------------------------------------------------------
    // Only rx_sync and rx_prev are looked at; rx_meta may be metastable
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= CAN_RX;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    assign sof  = rx_prev & ~rx_sync;   // Recessive to dominant
    assign busy = RX_BUSY | TX_BUSY;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Writes land on the edge where the master sees PREADY high
    assign apb_wr  = PSEL & PENABLE & PWRITE & PREADY;
    assign ctrl_wr = apb_wr & (PADDR == ADDR_MASTER_CONTROL);
    assign stat_wr = apb_wr & (PADDR == ADDR_MASTER_STATUS);
    assign ie_wr   = apb_wr & (PADDR == ADDR_IRQ_ENABLE);
    assign mapped  = (PADDR == ADDR_MASTER_CONTROL) | (PADDR == ADDR_MASTER_STATUS) |
                     (PADDR == ADDR_DIAGNOSTIC) | (PADDR == ADDR_IRQ_ENABLE);

    // Status byte, reserved bits held at zero
    always_comb begin
        status_val               = 8'h00;
        status_val[MS_INIT_ACK]  = (mode == MODE_INIT);          // see [RULE22]
        status_val[MS_SLEEP_ACK] = (mode == MODE_SLEEP);         // see [RULE20]
        status_val[MS_ERROR]     = error_flag;
        status_val[MS_WAKEUP]    = wakeup_flag;
        status_val[MS_TX_ACTIVE] = tx_active;
        status_val[MS_RX_ACTIVE] = rx_active;                    // see [RULE19]
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        read_val = 8'h00;
        case (PADDR)
            ADDR_MASTER_CONTROL: read_val = ctrl;
            ADDR_MASTER_STATUS:  read_val = status_val;           // see [RULE13]
            ADDR_DIAGNOSTIC:     read_val[DIAG_RX_LEVEL] = rx_sync; // see [RULE17]
            ADDR_IRQ_ENABLE:     read_val = irq_en;
            default:             read_val = 8'h00;
        endcase
    end

    // One wait state: PREADY rises in the second access cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
            if (PSEL & PENABLE & ~PREADY) begin
                PRDATA <= {24'h00_0000, read_val};
            end
        end
    end

    // ------------------------------------------------------------------
    // Control and interrupt enable registers
    // ------------------------------------------------------------------
    // Software write wins over the hardware sleep clear in the same cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl <= MASTER_CONTROL_RESET;                         // see [RULE12]
        end else if (ctrl_wr) begin
            ctrl          <= PWDATA[7:0];
            ctrl.reserved <= 1'b0;
        end else if (mode == MODE_SLEEP && sof && ctrl.auto_wakeup_select) begin
            ctrl.sleep_request <= 1'b0;                           // see [RULE3]
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            irq_en <= IRQ_ENABLE_RESET;
        end else if (ie_wr) begin
            irq_en <= PWDATA[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wakeup_flag <= 1'b0;
            error_flag  <= 1'b0;
        end else begin
            wakeup_flag <= (mode == MODE_SLEEP && sof) |
                           (wakeup_flag & ~(stat_wr & PWDATA[MS_WAKEUP])); // see [RULE15]
            error_flag  <= ERR_EVENT |
                           (error_flag & ~(stat_wr & PWDATA[MS_ERROR]));   // see [RULE16]
        end
    end

    // Bus role flags and status change interrupt
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_active  <= 1'b0;
            tx_active  <= 1'b0;
            STATUS_IRQ <= 1'b0;
        end else begin
            rx_active  <= RX_BUSY;                                // see [RULE14]
            tx_active  <= TX_BUSY;                                // see [RULE14]
            STATUS_IRQ <= (wakeup_flag & irq_en[IE_WAKEUP]) |
                          (error_flag & irq_en[IE_ERROR]);        // see [RULE15] [RULE16]
        end
    end

    // ------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------
    assign sync_done = BIT_TICK & rx_sync & (sync_cnt == SYNC_BITS_LAST);

    // Busy frames hold normal mode until their end
    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_SLEEP: begin
                if (sof && ctrl.auto_wakeup_select) begin
                    next_mode = MODE_SYNC;                        // see [RULE3]
                end else if (!ctrl.sleep_request) begin
                    next_mode = ctrl.init_request ? MODE_INIT : MODE_SYNC; // see [RULE2]
                end
            end
            MODE_INIT: begin
                if (ctrl.sleep_request) begin
                    next_mode = MODE_SLEEP;
                end else if (!ctrl.init_request) begin
                    next_mode = MODE_SYNC;
                end
            end
            MODE_SYNC: begin
                if (ctrl.init_request) begin
                    next_mode = MODE_INIT;
                end else if (ctrl.sleep_request) begin
                    next_mode = MODE_SLEEP;
                end else if (sync_done) begin
                    next_mode = MODE_NORMAL;                      // see [RULE10]
                end
            end
            MODE_NORMAL: begin
                if (!busy && ctrl.init_request) begin
                    next_mode = MODE_INIT;                        // see [RULE11] [RULE22]
                end else if (!busy && ctrl.sleep_request) begin
                    next_mode = MODE_SLEEP;                       // see [RULE9] [RULE22]
                end
            end
            default: next_mode = MODE_SLEEP;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode <= MODE_SLEEP;                                   // see [RULE12]
            MODE <= MODE_SLEEP;
        end else begin
            mode <= next_mode;
            MODE <= next_mode;
        end
    end

    // Recessive run counter for bus integration; dominant restarts it
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_cnt <= 4'h0;
        end else if (mode != MODE_SYNC || (BIT_TICK && !rx_sync)) begin
            sync_cnt <= 4'h0;
        end else if (BIT_TICK && sync_cnt != SYNC_BITS_LAST) begin
            sync_cnt <= sync_cnt + 4'h1;                          // see [RULE10]
        end
    end

    // ------------------------------------------------------------------
    // Bus-off recovery
    // ------------------------------------------------------------------
    // Manual recovery is armed by a pass through init mode while bus-off
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sw_recover <= 1'b0;
        end else if (!BUS_OFF) begin
            sw_recover <= 1'b0;
        end else if (mode == MODE_INIT && !ctrl.init_request) begin
            sw_recover <= 1'b1;                                   // see [RULE1]
        end
    end

    assign rec_run = BUS_OFF & (ctrl.auto_busoff_recovery | sw_recover);

    // 128 groups of 11 recessive bits; a dominant bit restarts the group
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rec_bits    <= 4'h0;
            rec_groups  <= 7'h00;
            BUSOFF_EXIT <= 1'b0;
        end else begin
            BUSOFF_EXIT <= 1'b0;
            if (!rec_run) begin
                rec_bits   <= 4'h0;
                rec_groups <= 7'h00;
            end else if (BIT_TICK && !rx_sync) begin
                rec_bits <= 4'h0;
            end else if (BIT_TICK && rec_bits == SYNC_BITS_LAST) begin
                rec_bits <= 4'h0;
                if (rec_groups == RECOVERY_GROUPS_LAST) begin
                    rec_groups  <= 7'h00;
                    BUSOFF_EXIT <= 1'b1;                          // see [RULE1]
                end else begin
                    rec_groups <= rec_groups + 7'h01;
                end
            end else if (BIT_TICK) begin
                rec_bits <= rec_bits + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit policy
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TX_RETRY  <= 1'b0;
            TX_ABORT  <= 1'b0;
            TX_SELECT <= 1'b0;
        end else begin
            TX_RETRY <= TX_FAIL & ~ctrl.single_shot_tx;           // see [RULE4]
            TX_ABORT <= TX_FAIL & ctrl.single_shot_tx;            // see [RULE5]
            // Equal identifiers go to mailbox 0
            if (MB_PENDING == 2'b11) begin
                TX_SELECT <= ctrl.tx_order_select ? MB1_OLDER : (MB1_ID < MB0_ID); // see [RULE8]
            end else begin
                TX_SELECT <= MB_PENDING[1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive FIFO pointers
    // ------------------------------------------------------------------
    assign rel_ok    = FIFO_RELEASE & (FIFO_PENDING != 2'h0);
    assign full_now  = (FIFO_PENDING == FIFO_FULL_COUNT) & ~rel_ok;
    // A stale pointer still points at the latest message, not past it
    assign last_slot = stale ? wptr : (wptr == 2'h0) ? FIFO_LAST_SLOT : wptr - 2'h1;

    // The stale pointer persists until reset, as the silicon does
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wptr         <= 2'h0;
            READ_SLOT    <= 2'h0;
            FIFO_PENDING <= 2'h0;
            stale        <= 1'b0;
            STORE_WE     <= 1'b0;
            STORE_SLOT   <= 2'h0;
            RX_DISCARD   <= 1'b0;
        end else begin
            STORE_WE   <= 1'b0;
            RX_DISCARD <= 1'b0;
            if (rel_ok) begin
                READ_SLOT <= (READ_SLOT == FIFO_LAST_SLOT) ? 2'h0 : READ_SLOT + 2'h1;
            end
            if (MSG_STORE && full_now && ctrl.rx_fifo_lock) begin
                RX_DISCARD <= 1'b1;                               // see [RULE7]
            end else if (MSG_STORE && (full_now || stale)) begin
                STORE_WE   <= 1'b1;
                STORE_SLOT <= last_slot;                          // see [RULE6] [RULE21]
                if (!full_now) begin
                    FIFO_PENDING <= FIFO_PENDING + 2'h1 - {1'b0, rel_ok};
                end else if (rel_ok) begin
                    FIFO_PENDING <= FIFO_PENDING - 2'h1;
                end
            end else if (MSG_STORE) begin
                STORE_WE     <= 1'b1;
                STORE_SLOT   <= wptr;
                FIFO_PENDING <= FIFO_PENDING + 2'h1 - {1'b0, rel_ok};
                if (rel_ok && FIFO_PENDING == FIFO_STALE_COUNT) begin
                    stale <= 1'b1;                                // see [RULE21]
                end else begin
                    wptr <= (wptr == FIFO_LAST_SLOT) ? 2'h0 : wptr + 2'h1;
                end
            end else if (rel_ok) begin
                FIFO_PENDING <= FIFO_PENDING - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    busoff_exit_count_a: assert property ( // see [RULE1]
        $rose(BUSOFF_EXIT) |-> $past(rec_groups) == RECOVERY_GROUPS_LAST && $past(rec_run))
        else $error("bus-off exit without full recessive count");

    sleep_hold_a: assert property ( // see [RULE2]
        mode == MODE_SLEEP && ctrl.sleep_request && !ctrl.auto_wakeup_select
        |=> mode == MODE_SLEEP)
        else $error("sleep left while still requested");

    auto_wake_a: assert property ( // see [RULE3]
        mode == MODE_SLEEP && sof && ctrl.auto_wakeup_select && !ctrl_wr
        |=> !ctrl.sleep_request && !status_val[MS_SLEEP_ACK] && wakeup_flag)
        else $error("auto wake-up did not clear sleep");

    retry_policy_a: assert property ( // see [RULE4]
        TX_FAIL && !ctrl.single_shot_tx |=> TX_RETRY && !TX_ABORT)
        else $error("failed message not retried");

    single_shot_a: assert property ( // see [RULE5]
        TX_FAIL && ctrl.single_shot_tx |=> TX_ABORT && !TX_RETRY)
        else $error("single-shot message retried");

    fifo_overwrite_a: assert property ( // see [RULE6]
        MSG_STORE && full_now && !ctrl.rx_fifo_lock
        |=> STORE_WE && STORE_SLOT == $past(last_slot) && FIFO_PENDING == FIFO_FULL_COUNT)
        else $error("full unlocked FIFO did not overwrite last");

    fifo_discard_a: assert property ( // see [RULE7]
        MSG_STORE && full_now && ctrl.rx_fifo_lock |=> RX_DISCARD && !STORE_WE)
        else $error("locked FIFO stored on overrun");

    tx_order_a: assert property ( // see [RULE8]
        MB_PENDING == 2'b11 && ctrl.tx_order_select |=> TX_SELECT == $past(MB1_OLDER))
        else $error("chronological order not kept");

    frame_guard_a: assert property ( // see [RULE9]
        mode == MODE_NORMAL && busy |=> mode == MODE_NORMAL)
        else $error("mode left during a frame");

    sync_exit_a: assert property ( // see [RULE10]
        mode == MODE_SYNC ##1 mode == MODE_NORMAL |-> $past(sync_cnt) == SYNC_BITS_LAST)
        else $error("normal mode before 11 recessive bits");

    stale_sticky_a: assert property ( // see [RULE21]
        stale |=> stale && $stable(wptr))
        else $error("stale FIFO pointer recovered");

    flag_set_wins_a: assert property ( // see [RULE13]
        ERR_EVENT && stat_wr && PWDATA[MS_ERROR] |=> error_flag)
        else $error("error event lost to clear");

    wake_seen_c: cover property (mode == MODE_SLEEP ##1 mode == MODE_SYNC ##[1:200] mode == MODE_NORMAL);
    busoff_done_c: cover property (BUSOFF_EXIT);
    fifo_stale_c: cover property ($rose(stale));
    init_entry_c: cover property (mode == MODE_NORMAL ##1 mode == MODE_INIT);

endmodule : can_mode_control_status

`default_nettype wire

// >>> can_mode_control_status_tb_top.sv
// Self-checking bench for the CAN mode control and status block
`timescale 1ns/1ps
`default_nettype none
module can_mode_control_status_tb_top;
    import can_mode_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d, e; logic s;} row_t;
    logic        CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0;
    logic        TX_BUSY = 0, BUS_OFF = 0, ERR_EVENT = 0, FIFO_RELEASE = 0;
    logic        TX_FAIL = 0, MB1_OLDER = 0, MSG_STORE = 0, er;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [1:0]  MB_PENDING = 2'h3, MODE, STORE_SLOT, READ_SLOT, FIFO_PENDING;
    logic [10:0] MB0_ID = 11'h005, MB1_ID = 11'h003;
    logic        PREADY, PSLVERR, CAN_RX, BIT_TICK, RX_BUSY, BUSOFF_EXIT, TX_RETRY;
    logic        TX_ABORT, TX_SELECT, STORE_WE, RX_DISCARD, STATUS_IRQ;
    int          num_errors = 0, n_tests = 0, cyc = 0, i;
    // Register cases: write, read back, expected data and error
    row_t rows[4] = '{'{8'h0C, 32'hC0, 32'hC0, 1'b0}, '{8'h10, 32'hFF, 32'h0, 1'b1},
                      '{8'h08, 32'h0, 32'h08, 1'b0}, '{8'h00, 32'h01, 32'h01, 1'b0}};
    can_mode_control_status can_mode_control_status_inst (.CLK, .SYS_RST, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CAN_RX,
        .BIT_TICK, .RX_BUSY, .TX_BUSY, .BUS_OFF, .ERR_EVENT, .TX_FAIL, .MB_PENDING,
        .MB0_ID, .MB1_ID, .MB1_OLDER, .MSG_STORE, .FIFO_RELEASE, .MODE, .BUSOFF_EXIT,
        .TX_RETRY, .TX_ABORT, .TX_SELECT, .STORE_WE, .STORE_SLOT, .RX_DISCARD,
        .READ_SLOT, .FIFO_PENDING, .STATUS_IRQ);
    can_bus_model can_bus_model_inst (.CLK, .go, .CAN_RX, .RX_BUSY, .BIT_TICK);
    // 40 MHz clock
    always #12.5 CLK = ~CLK;
    task results;
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    // Hang guard, far above the expected run length
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // APB transfer; request held until PREADY is seen high
    task apb(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge CLK) {PSEL, PADDR, PWRITE, PWDATA} <= {1'b1, a, w, d};
        @(posedge CLK) PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        // Answer taken and request dropped at the edge that sees PREADY
        {er, rd} = {PSLVERR, PRDATA};
        {PSEL, PENABLE} <= 2'b00;
        #1;
    endtask : apb
    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(a, 32'h0, 1'b0);
        chk(rd, e);
    endtask : rdc
    task wait_mode(input logic [1:0] m);
        for (int k = 0; k < 80 && MODE !== m; k++) begin @(posedge CLK); #1; end
        chk(MODE, m);
    endtask : wait_mode
    // One-cycle pulses: bit 0 store, 1 tx failure, 2 frame start, 3 error, 4 release
    task pulse(input logic [4:0] w);
        @(posedge CLK) {FIFO_RELEASE, ERR_EVENT, go, TX_FAIL, MSG_STORE} <= w;
        @(posedge CLK) {FIFO_RELEASE, ERR_EVENT, go, TX_FAIL, MSG_STORE} <= 5'h00;
        #1;
    endtask : pulse
    // Main sequence
    initial begin
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        #1 chk(MODE, 2'h0);
        rdc(8'h00, 32'h02);
        rdc(8'h04, 32'h02);
        chk(TX_SELECT, 1'b1);
        for (i = 0; i < 4; i++) begin
            apb(rows[i].a, rows[i].d, 1'b1);
            apb(rows[i].a, 32'h0, 1'b0);
            chk(er, rows[i].s);
            chk(rd, rows[i].e);
        end
        wait_mode(2'h1);
        rdc(8'h04, 32'h01);
        apb(8'h00, 32'h00, 1'b1);
        wait_mode(2'h3);
        rdc(8'h04, 32'h00);
        // Sleep request made in mid-frame
        pulse(5'h04);
        rdc(8'h04, 32'h20);
        apb(8'h00, 32'h02, 1'b1);
        chk(MODE, 2'h3);
        wait_mode(2'h0);
        rdc(8'h04, 32'h02);
        apb(8'h00, 32'h22, 1'b1);
        pulse(5'h04);
        wait_mode(2'h2);
        rdc(8'h00, 32'h20);
        wait_mode(2'h3);
        rdc(8'h04, 32'h08);
        chk(STATUS_IRQ, 1'b1);
        apb(8'h04, 32'h08, 1'b1);
        rdc(8'h04, 32'h00);
        chk(STATUS_IRQ, 1'b0);
        for (i = 0; i < 4; i++) pulse(5'h01);
        chk({FIFO_PENDING, STORE_WE, STORE_SLOT}, 5'h1E);
        apb(8'h00, 32'h28, 1'b1);
        pulse(5'h01);
        chk({RX_DISCARD, STORE_WE}, 2'b10);
        // Release only while no frame is being received
        pulse(5'h10);
        chk({FIFO_PENDING, READ_SLOT}, 4'h9);
        // Release coinciding with a store at two pending
        pulse(5'h11);
        pulse(5'h01);
        chk({FIFO_PENDING, STORE_SLOT}, 4'hC);
        for (i = 0; i < 2; i++) begin
            apb(8'h00, 32'h2C | (i << 4), 1'b1);
            pulse(5'h02);
            chk({TX_RETRY, TX_ABORT, TX_SELECT}, i ? 3'b010 : 3'b100);
        end
        pulse(5'h08);
        rdc(8'h04, 32'h04);
        chk(STATUS_IRQ, 1'b1);
        // Init request held off by a frame in progress
        @(posedge CLK) TX_BUSY <= 1'b1;
        apb(8'h00, 32'h3D, 1'b1);
        rdc(8'h04, 32'h14);
        chk(MODE, 2'h3);
        @(posedge CLK) {TX_BUSY, BUS_OFF} <= 2'b01;
        wait_mode(2'h1);
        // Leaving init while bus-off starts the recovery count
        apb(8'h00, 32'h3C, 1'b1);
        for (i = 0; BUSOFF_EXIT !== 1'b1; i++) begin @(posedge CLK); #1; end
        chk(i, 128 * 11 + 1);
        // Reset in mid-run
        @(posedge CLK) {SYS_RST, BUS_OFF} <= 2'b10;
        @(posedge CLK) SYS_RST <= 1'b0;
        #1 chk({MODE, FIFO_PENDING, STATUS_IRQ}, 5'h00);
        rdc(8'h04, 32'h02);
        results();
    end
endmodule : can_mode_control_status_tb_top
`default_nettype wire

// >>> can_mode_pkg.sv
// Constants, types and register map of the CAN mode control and status block
//
// Contract
// [RULE1] Bus-off exit on software request, or by itself after 128 x 11 recessive bits.
// [RULE2] Without auto wake-up, sleep lasts until software clears the sleep request.
// [RULE3] With auto wake-up, start-of-frame ends sleep; hardware clears sleep request and acknowledge.
// [RULE4] Without single-shot, a failed message is retried until sent.
// [RULE5] With single-shot, each message is sent once, whatever the outcome.
// [RULE6] Unlocked full FIFO: next accepted message overwrites the latest stored one.
// [RULE7] Locked full FIFO: next message is discarded, stored ones kept.
// [RULE8] Pending mailboxes ordered by identifier when order select is 0, else chronologically.
// [RULE9] Sleep is entered only after the frame in progress completes.
// [RULE10] Leaving init waits for 11 recessive bits, then normal mode, init ack cleared; here init ack clears on entering sync mode, before the 11 bits.
// [RULE11] Init request waits for the current frame, then init mode with ack set.
// [RULE12] Master control and master status both reset to 02h.
// [RULE13] Status flags clear on writing one; zero leaves them; reserved bits read zero.
// [RULE14] Receiver-active and transmitter-active flags follow the bus role.
// [RULE15] Start-of-frame in sleep sets wake-up flag; interrupt if enabled; software clears.
// [RULE16] Enabled error-status event sets error flag; interrupt if enabled.
// [RULE17] Receive pin level readable as diagnostic register bit 3.
// [RULE18] Host releases a two-deep FIFO only on dominant Rx or 8 recessive bits; the FIFO here has three slots.
// [RULE19] Receiver-active flag sits at master status bit 5.
// [RULE20] Sleep acknowledge set while in sleep mode, cleared on leaving it.
// [RULE21] Release coinciding with a store at two pending leaves write pointer stale.
// [RULE22] Mode changes occur at frame boundaries; acks change with the mode itself.
`default_nettype none
package can_mode_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MASTER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MASTER_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_DIAGNOSTIC     = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h0C;

    localparam logic [7:0] MASTER_CONTROL_RESET = 8'h02;
    localparam logic [7:0] IRQ_ENABLE_RESET     = 8'h00;

    // Field positions
    localparam int MS_INIT_ACK   = 0;
    localparam int MS_SLEEP_ACK  = 1;
    localparam int MS_ERROR      = 2;
    localparam int MS_WAKEUP     = 3;
    localparam int MS_TX_ACTIVE  = 4;
    localparam int MS_RX_ACTIVE  = 5;
    localparam int DIAG_RX_LEVEL = 3;
    localparam int IE_ERROR      = 6;
    localparam int IE_WAKEUP     = 7;

    // ------------------------------------------------------------------
    // Bit time and FIFO counts
    // ------------------------------------------------------------------
    localparam logic [3:0] SYNC_BITS_LAST       = 4'hA;   // 11 recessive bits
    localparam logic [6:0] RECOVERY_GROUPS_LAST = 7'h7F;  // 128 groups
    localparam logic [1:0] FIFO_FULL_COUNT      = 2'h3;
    localparam logic [1:0] FIFO_STALE_COUNT     = 2'h2;
    localparam logic [1:0] FIFO_LAST_SLOT       = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic reserved;
        logic auto_busoff_recovery;
        logic auto_wakeup_select;
        logic single_shot_tx;
        logic rx_fifo_lock;
        logic tx_order_select;
        logic sleep_request;
        logic init_request;
    } ctrl_t;

    typedef enum logic [1:0] {
        MODE_SLEEP  = 2'b00,
        MODE_INIT   = 2'b01,
        MODE_SYNC   = 2'b10,
        MODE_NORMAL = 2'b11
    } mode_t;

endpackage : can_mode_pkg

`default_nettype wire
